// *** include/cmpl_pkg.sv ***
// Constants shared by the comparator output and latch logic
package cmpl_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam int unsigned ADDR_W                    = 4;
  localparam logic [3:0]  SHARED_CONTROL_ADDR       = 4'h0;
  localparam logic [3:0]  LATCH_CONTROL_ADDR        = 4'h1;

  // ********************************************************************
  // Shared control register fields
  // ********************************************************************
  localparam int unsigned COMP_A_OUTPUT_MIRROR_BIT    = 7;
  localparam int unsigned COMP_B_OUTPUT_MIRROR_BIT    = 6;
  localparam int unsigned COMP_A_REFERENCE_SELECT_BIT = 5;
  localparam int unsigned COMP_B_REFERENCE_SELECT_BIT = 4;
  localparam int unsigned TIMER_GATE_SOURCE_SEL_BIT   = 1;
  localparam int unsigned COMP_B_SYNC_ENABLE_BIT      = 0;
  localparam logic [7:0]  SHARED_CONTROL_RESET        = 8'h02;

  // ********************************************************************
  // Latch control register fields
  // ********************************************************************
  localparam int unsigned LATCH_OUTPUT_SEL_HIGH_BIT   = 7;
  localparam int unsigned LATCH_OUTPUT_SEL_LOW_BIT    = 6;
  localparam int unsigned COMP_A_SET_ENABLE_BIT       = 5;
  localparam int unsigned COMP_B_RESET_ENABLE_BIT     = 4;
  localparam int unsigned SOFTWARE_SET_PULSE_BIT      = 3;
  localparam int unsigned SOFTWARE_RESET_PULSE_BIT    = 2;
  localparam int unsigned FIXED_REFERENCE_ENABLE_BIT  = 0;
  localparam logic [7:0]  LATCH_CONTROL_RESET         = 8'h00;

  // ********************************************************************
  // Synchroniser lanes
  // ********************************************************************
  localparam int unsigned SYNC_W          = 5;
  localparam int unsigned LANE_COMP_A     = 0;
  localparam int unsigned LANE_COMP_B     = 1;
  localparam int unsigned LANE_EXT_GATE   = 2;
  localparam int unsigned LANE_TMR_RAW    = 3;
  localparam int unsigned LANE_TMR_PRESC  = 4;

endpackage : cmpl_pkg

// *** include/cmpl_sync_if.sv ***
// Carrier between the pin synchroniser and the main logic
`timescale 1ns/1ps
interface cmpl_sync_if #(
  parameter int unsigned W = 5
);
  logic [W-1:0] raw;
  logic [W-1:0] level;

  modport sync_side (input raw, output level);
  modport user_side (output raw, input level);
endinterface : cmpl_sync_if

// *** src/cmpl_sync.sv ***
// Three-flop synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/1ps
module cmpl_sync #(
  parameter int unsigned W = 5
) (
  input  wire logic           clock_i,
  input  wire logic           resetn_i,
  cmpl_sync_if.sync_side      port_if
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;
  logic [W-1:0] stage3_r;
  logic [W-1:0] level_r;

  // Shift chain; the first stage feeds only the second
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
    end else begin
      stage1_r <= port_if.raw;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // A change is taken only once stages two and three agree, masking metastable glitches
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      level_r <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2_r[i] == stage3_r[i]) begin
          level_r[i] <= stage3_r[i];
        end
      end
    end
  end

  assign port_if.level = level_r;

endmodule : cmpl_sync

// *** src/cmpl_top.sv ***
// Comparator output routing, timer gate select and set/reset latch logic
`timescale 1ns/1ps

module cmpl_top #(
  parameter int unsigned ADDR_W = cmpl_pkg::ADDR_W
) (
  input  wire logic              clock_i,
  input  wire logic              resetn_i,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_write_i,
  input  wire logic              reg_read_i,
  output logic      [7:0]        reg_rdata_o,
  // Analog side and pins
  input  wire logic              comp_a_output_i,
  input  wire logic              comp_b_output_i,
  input  wire logic              external_gate_pin_i,
  input  wire logic              timer_raw_clock_i,
  input  wire logic              timer_prescaled_clock_i,
  input  wire logic              timer_prescaler_used_i,
  input  wire logic              comp_a_output_pin_enable_i,
  input  wire logic              comp_b_output_pin_enable_i,
  input  wire logic              pin_a_direction_bit_i,
  input  wire logic              pin_b_direction_bit_i,
  // Toward the gated timer
  output logic                   timer_gate_o,
  output logic                   timer_increment_o,
  output logic                   comp_b_synced_output_o,
  // Comparator status toward main control registers
  output logic                   comp_a_status_o,
  output logic                   comp_b_status_o,
  // Reference routing
  output logic                   comp_a_reference_select_o,
  output logic                   comp_b_reference_select_o,
  output logic                   ladder_current_enable_o,
  output logic                   fixed_reference_enable_o,
  // Port pin paths
  output logic                   pin_a_out_o,
  output logic                   pin_a_oe_o,
  output logic                   pin_b_out_o,
  output logic                   pin_b_oe_o,
  output logic                   latch_q_o
);

  // ******************************************************************
  // Input synchronisation
  // ******************************************************************
  cmpl_sync_if #(.W(cmpl_pkg::SYNC_W)) sync_if ();

  // All pin-side levels share one synchroniser instance
  assign sync_if.raw = {timer_prescaled_clock_i,
                        timer_raw_clock_i,
                        external_gate_pin_i,
                        comp_b_output_i,
                        comp_a_output_i};

  cmpl_sync #(
    .W        (cmpl_pkg::SYNC_W)
  ) u_sync (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .port_if  (sync_if)
  );

  logic comp_a_lvl;
  logic comp_b_lvl;
  logic ext_gate_lvl;
  logic tmr_raw_lvl;
  logic tmr_presc_lvl;

  assign comp_a_lvl    = sync_if.level[cmpl_pkg::LANE_COMP_A];
  assign comp_b_lvl    = sync_if.level[cmpl_pkg::LANE_COMP_B];
  assign ext_gate_lvl  = sync_if.level[cmpl_pkg::LANE_EXT_GATE];
  assign tmr_raw_lvl   = sync_if.level[cmpl_pkg::LANE_TMR_RAW];
  assign tmr_presc_lvl = sync_if.level[cmpl_pkg::LANE_TMR_PRESC];

  // ******************************************************************
  // Registers
  // ******************************************************************
  logic       comp_a_ref_sel_r;
  logic       comp_b_ref_sel_r;
  logic       timer_gate_source_select_r;
  logic       comp_b_sync_enable_r;
  logic       latch_output_select_high_r;
  logic       latch_output_select_low_r;
  logic       comp_a_set_enable_r;
  logic       comp_b_reset_enable_r;
  logic       fixed_reference_enable_r;
  logic       software_set_pulse_r;
  logic       software_reset_pulse_r;
  logic       wr_shared;
  logic       wr_latch;

  assign wr_shared = reg_write_i && (reg_addr_i == ADDR_W'(cmpl_pkg::SHARED_CONTROL_ADDR));
  assign wr_latch  = reg_write_i && (reg_addr_i == ADDR_W'(cmpl_pkg::LATCH_CONTROL_ADDR));

  // Shared control writable fields; mirror bits are read only
  // reset value
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      comp_a_ref_sel_r           <= cmpl_pkg::SHARED_CONTROL_RESET[
                                      cmpl_pkg::COMP_A_REFERENCE_SELECT_BIT];
      comp_b_ref_sel_r           <= cmpl_pkg::SHARED_CONTROL_RESET[
                                      cmpl_pkg::COMP_B_REFERENCE_SELECT_BIT];
      timer_gate_source_select_r <= cmpl_pkg::SHARED_CONTROL_RESET[
                                      cmpl_pkg::TIMER_GATE_SOURCE_SEL_BIT];
      comp_b_sync_enable_r       <= cmpl_pkg::SHARED_CONTROL_RESET[
                                      cmpl_pkg::COMP_B_SYNC_ENABLE_BIT];
    end else if (wr_shared) begin
      comp_a_ref_sel_r           <= reg_wdata_i[cmpl_pkg::COMP_A_REFERENCE_SELECT_BIT];
      comp_b_ref_sel_r           <= reg_wdata_i[cmpl_pkg::COMP_B_REFERENCE_SELECT_BIT];
      timer_gate_source_select_r <= reg_wdata_i[cmpl_pkg::TIMER_GATE_SOURCE_SEL_BIT];
      comp_b_sync_enable_r       <= reg_wdata_i[cmpl_pkg::COMP_B_SYNC_ENABLE_BIT];
    end
  end

  // Latch control stored fields
  // select bits clear on reset so pins carry raw outputs
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latch_output_select_high_r <= cmpl_pkg::LATCH_CONTROL_RESET[
                                      cmpl_pkg::LATCH_OUTPUT_SEL_HIGH_BIT];
      latch_output_select_low_r  <= cmpl_pkg::LATCH_CONTROL_RESET[
                                      cmpl_pkg::LATCH_OUTPUT_SEL_LOW_BIT];
      comp_a_set_enable_r        <= cmpl_pkg::LATCH_CONTROL_RESET[
                                      cmpl_pkg::COMP_A_SET_ENABLE_BIT];
      comp_b_reset_enable_r      <= cmpl_pkg::LATCH_CONTROL_RESET[
                                      cmpl_pkg::COMP_B_RESET_ENABLE_BIT];
      fixed_reference_enable_r   <= cmpl_pkg::LATCH_CONTROL_RESET[
                                      cmpl_pkg::FIXED_REFERENCE_ENABLE_BIT];
    end else if (wr_latch) begin
      latch_output_select_high_r <= reg_wdata_i[cmpl_pkg::LATCH_OUTPUT_SEL_HIGH_BIT];
      latch_output_select_low_r  <= reg_wdata_i[cmpl_pkg::LATCH_OUTPUT_SEL_LOW_BIT];
      comp_a_set_enable_r        <= reg_wdata_i[cmpl_pkg::COMP_A_SET_ENABLE_BIT];
      comp_b_reset_enable_r      <= reg_wdata_i[cmpl_pkg::COMP_B_RESET_ENABLE_BIT];
      fixed_reference_enable_r   <= reg_wdata_i[cmpl_pkg::FIXED_REFERENCE_ENABLE_BIT];
    end
  end

  // Pulse generators; a written zero is simply ignored
  // self-clearing set and reset pulses
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      software_set_pulse_r   <= 1'b0;
      software_reset_pulse_r <= 1'b0;
    end else begin
      software_set_pulse_r   <= wr_latch && reg_wdata_i[cmpl_pkg::SOFTWARE_SET_PULSE_BIT];
      software_reset_pulse_r <= wr_latch && reg_wdata_i[cmpl_pkg::SOFTWARE_RESET_PULSE_BIT];
    end
  end

  // ******************************************************************
  // Read port
  // ******************************************************************
  logic [7:0] shared_view;
  logic [7:0] latch_view;

  // Unimplemented and pulse bits fall out as zero by construction
  // reserved bits zero
  // live mirrors of both comparators side by side
  always_comb begin
    shared_view = 8'h00;
    shared_view[cmpl_pkg::COMP_A_OUTPUT_MIRROR_BIT]    = comp_a_lvl;
    shared_view[cmpl_pkg::COMP_B_OUTPUT_MIRROR_BIT]    = comp_b_lvl;
    shared_view[cmpl_pkg::COMP_A_REFERENCE_SELECT_BIT] = comp_a_ref_sel_r;
    shared_view[cmpl_pkg::COMP_B_REFERENCE_SELECT_BIT] = comp_b_ref_sel_r;
    shared_view[cmpl_pkg::TIMER_GATE_SOURCE_SEL_BIT]   = timer_gate_source_select_r;
    shared_view[cmpl_pkg::COMP_B_SYNC_ENABLE_BIT]      = comp_b_sync_enable_r;
  end

  // pulse bits always read back zero
  always_comb begin
    latch_view = 8'h00;
    latch_view[cmpl_pkg::LATCH_OUTPUT_SEL_HIGH_BIT]  = latch_output_select_high_r;
    latch_view[cmpl_pkg::LATCH_OUTPUT_SEL_LOW_BIT]   = latch_output_select_low_r;
    latch_view[cmpl_pkg::COMP_A_SET_ENABLE_BIT]      = comp_a_set_enable_r;
    latch_view[cmpl_pkg::COMP_B_RESET_ENABLE_BIT]    = comp_b_reset_enable_r;
    latch_view[cmpl_pkg::FIXED_REFERENCE_ENABLE_BIT] = fixed_reference_enable_r;
  end

  // Read data stand one cycle after the strobe, zero otherwise and when unmapped
  // no read strobe leaves toward the mismatch latches
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_read_i && reg_addr_i == ADDR_W'(cmpl_pkg::SHARED_CONTROL_ADDR)) begin
      reg_rdata_o <= shared_view;
    end else if (reg_read_i && reg_addr_i == ADDR_W'(cmpl_pkg::LATCH_CONTROL_ADDR)) begin
      reg_rdata_o <= latch_view;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ******************************************************************
  // Timer clock edges and comparator B capture
  // ******************************************************************
  logic tmr_clk_sel;
  logic tmr_clk_prev_r;
  logic tmr_fall;
  logic tmr_rise;
  logic comp_b_captured_r;
  logic comp_b_synced;

  // prescaled clock clocks the capture when a prescaler is used
  assign tmr_clk_sel = timer_prescaler_used_i ? tmr_presc_lvl : tmr_raw_lvl;

  // Edge detection runs on the filtered level, never on a raw stage
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tmr_clk_prev_r <= 1'b0;
    end else begin
      tmr_clk_prev_r <= tmr_clk_sel;
    end
  end

  assign tmr_fall = tmr_clk_prev_r && !tmr_clk_sel;
  assign tmr_rise = !tmr_clk_prev_r && tmr_clk_sel;

  // capture on the falling edge of the timer clock
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      comp_b_captured_r <= 1'b0;
    end else if (tmr_fall) begin
      comp_b_captured_r <= comp_b_lvl;
    end
  end

  // software is expected to keep sync on while comparator B gates
  assign comp_b_synced = comp_b_sync_enable_r ? comp_b_captured_r : comp_b_lvl;

  logic gate_nxt;

  assign gate_nxt = timer_gate_source_select_r ? ext_gate_lvl : comp_b_synced;

  // Gate and count strobe toward the timer
  // increment only on the rising edge, opposite the capture edge
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timer_gate_o           <= 1'b0;
      timer_increment_o      <= 1'b0;
      comp_b_synced_output_o <= 1'b0;
    end else begin
      timer_gate_o           <= gate_nxt;
      timer_increment_o      <= tmr_rise && gate_nxt;
      comp_b_synced_output_o <= comp_b_synced;
    end
  end

  // ******************************************************************
  // Set/reset latch
  // ******************************************************************
  logic latch_set;
  logic latch_reset;
  logic latch_q_r;

  assign latch_set   = (comp_a_set_enable_r && comp_a_lvl) || software_set_pulse_r;
  assign latch_reset = (comp_b_reset_enable_r && comp_b_lvl) || software_reset_pulse_r;

  // Re-evaluated every cycle, so a held input keeps acting like a level
  // level-sensitive set and reset
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latch_q_r <= 1'b0;
    end else if (latch_reset) begin
      latch_q_r <= 1'b0;
    end else if (latch_set) begin
      latch_q_r <= 1'b1;
    end
  end

  // ******************************************************************
  // Pin paths, references and status
  // ******************************************************************
  // pin A source select
  // pin B source select, inverted latch output
  // drive only with output enable set and direction cleared
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_a_out_o <= 1'b0;
      pin_b_out_o <= 1'b0;
      pin_a_oe_o  <= 1'b0;
      pin_b_oe_o  <= 1'b0;
      latch_q_o   <= 1'b0;
    end else begin
      pin_a_out_o <= latch_output_select_low_r ? latch_q_r : comp_a_lvl;
      pin_b_out_o <= latch_output_select_high_r ? !latch_q_r : comp_b_lvl;
      pin_a_oe_o  <= comp_a_output_pin_enable_i && !pin_a_direction_bit_i;
      pin_b_oe_o  <= comp_b_output_pin_enable_i && !pin_b_direction_bit_i;
      latch_q_o   <= latch_q_r;
    end
  end

  // Ladder draws current only while some comparator uses it
  // comparator A and B reference routing, ladder current and fixed reference
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      comp_a_reference_select_o <= 1'b0;
      comp_b_reference_select_o <= 1'b0;
      ladder_current_enable_o   <= 1'b0;
      fixed_reference_enable_o  <= 1'b0;
    end else begin
      comp_a_reference_select_o <= comp_a_ref_sel_r;
      comp_b_reference_select_o <= comp_b_ref_sel_r;
      ladder_current_enable_o   <= comp_a_ref_sel_r || comp_b_ref_sel_r;
      fixed_reference_enable_o  <= fixed_reference_enable_r;
    end
  end

  // Status follows the comparator itself, whatever the pin selects
  // true comparator output
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      comp_a_status_o <= 1'b0;
      comp_b_status_o <= 1'b0;
    end else begin
      comp_a_status_o <= comp_a_lvl;
      comp_b_status_o <= comp_b_lvl;
    end
  end

endmodule : cmpl_top

// *** sim/cmpl_far.sv ***
// Far-side model: comparator levels, gate pin, timer clocks and timer
`timescale 1ns/1ps
module cmpl_far (
  input  wire logic clock_i,
  input  wire logic timer_increment_i,
  output logic      comp_a_o,
  output logic      comp_b_o,
  output logic      gate_pin_o,
  output logic      raw_clk_o,
  output logic      presc_clk_o
);
  int incs = 0;
  // Timer clocks stand low outside bursts
  initial begin
    {comp_a_o, comp_b_o, gate_pin_o, raw_clk_o, presc_clk_o} = 5'h00;
  end
  always @(posedge clock_i) begin
    if (timer_increment_i) incs <= incs + 1;
  end
  // Levels change just after an edge
  task automatic set_in(input logic a, input logic b, input logic g);
    @(posedge clock_i);
    comp_a_o <= a;
    comp_b_o <= b;
    gate_pin_o <= g;
  endtask : set_in
  // Slow clock: six system cycles per phase, so the synchroniser sees it
  task automatic tclk(input bit presc, input int n);
    repeat (2 * n) begin
      repeat (6) @(posedge clock_i);
      if (presc) presc_clk_o <= ~presc_clk_o;
      else raw_clk_o <= ~raw_clk_o;
    end
  endtask : tclk
endmodule : cmpl_far

// *** sim/cmpl_chk.sv ***
// Port-level assertions for the comparator latch block
`timescale 1ns/1ps
module cmpl_chk #(
  parameter int unsigned ADDR_W = 4
) (
  input wire logic              clock_i,
  input wire logic              resetn_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0]        reg_wdata_i,
  input wire logic              reg_write_i,
  input wire logic              reg_read_i,
  input wire logic [7:0]        reg_rdata_o,
  input wire logic              comp_a_output_pin_enable_i,
  input wire logic              comp_b_output_pin_enable_i,
  input wire logic              pin_a_direction_bit_i,
  input wire logic              pin_b_direction_bit_i,
  input wire logic              pin_a_oe_o,
  input wire logic              pin_b_oe_o,
  input wire logic              comp_a_reference_select_o,
  input wire logic              comp_b_reference_select_o,
  input wire logic              ladder_current_enable_o,
  input wire logic              fixed_reference_enable_o,
  input wire logic              latch_q_o,
  input wire logic              timer_increment_o
);
  logic wr0, wr1, rd0, rd1;
  // Decoded strobes
  assign wr0 = reg_write_i && reg_addr_i == 4'h0;
  assign wr1 = reg_write_i && reg_addr_i == 4'h1;
  assign rd0 = reg_read_i && reg_addr_i == 4'h0;
  assign rd1 = reg_read_i && reg_addr_i == 4'h1;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  // ****
  // Assertions
  // ****
  a_ref_a_write: assert property (wr0 |-> ##2
    comp_a_reference_select_o == $past(reg_wdata_i[5], 2)) else $error("ref A select");
  a_ref_b_write: assert property (wr0 |-> ##2
    comp_b_reference_select_o == $past(reg_wdata_i[4], 2)) else $error("ref B select");
  a_ladder_current: assert property (ladder_current_enable_o ==
    (comp_a_reference_select_o | comp_b_reference_select_o)) else $error("ladder");
  a_fixed_ref_write: assert property (wr1 |-> ##2
    fixed_reference_enable_o == $past(reg_wdata_i[0], 2)) else $error("fixed ref");
  a_shared_zero_bits: assert property ($past(rd0) |->
    reg_rdata_o[3:2] == 2'h0) else $error("shared zero bits");
  a_latch_zero_bits: assert property ($past(rd1) |->
    reg_rdata_o[3:1] == 3'h0) else $error("latch zero bits");
  a_pulse_set: assert property (wr1 && reg_wdata_i[4:2] == 3'h2 |-> ##3
    latch_q_o) else $error("set pulse");
  a_pulse_reset: assert property (wr1 && reg_wdata_i[2] |-> ##3
    !latch_q_o) else $error("reset pulse");
  a_pin_a_enable: assert property (pin_a_oe_o |->
    $past(comp_a_output_pin_enable_i) && !$past(pin_a_direction_bit_i)) else $error("oe A");
  a_pin_b_enable: assert property (pin_b_oe_o |->
    $past(comp_b_output_pin_enable_i) && !$past(pin_b_direction_bit_i)) else $error("oe B");
  a_incr_single: assert property (timer_increment_o |=>
    !timer_increment_o) else $error("increment width");
  c_set: cover property (wr1 && reg_wdata_i[3]);
  c_incr: cover property (timer_increment_o);
  c_oe: cover property (pin_a_oe_o);
endmodule : cmpl_chk
bind cmpl_top cmpl_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// *** sim/tb.sv ***
// Self-checking bench for the comparator output and latch block
`timescale 1ns/1ps
module tb;
  typedef struct {logic [3:0] a; logic [7:0] w; logic [7:0] e;} cmpl_row_type;
  logic clock_i, resetn_i, wr, rd, ea, eb, da, db, pu;
  logic [3:0] ad;
  logic [7:0] wd, rdo;
  logic ca, cb, eg, rc, pc, tg, ti, sy, sa, sb, lq, pa, oa, pb, ob;
  int mismatches = 0, compares = 0, cyc = 0;
  cmpl_row_type rows [7] = '{'{4'h0, 8'hFF, 8'h33}, '{4'h0, 8'h00, 8'h00},
    '{4'h1, 8'hFF, 8'hF1}, '{4'h1, 8'h00, 8'h00}, '{4'h2, 8'hFF, 8'h00},
    '{4'hF, 8'hFF, 8'h00}, '{4'h0, 8'h02, 8'h02}};
  // Clock, 50 ns period
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  cmpl_top uut (.clock_i(clock_i), .resetn_i(resetn_i), .reg_addr_i(ad),
    .reg_wdata_i(wd), .reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdo),
    .comp_a_output_i(ca), .comp_b_output_i(cb), .external_gate_pin_i(eg),
    .timer_raw_clock_i(rc), .timer_prescaled_clock_i(pc), .timer_prescaler_used_i(pu),
    .comp_a_output_pin_enable_i(ea), .comp_b_output_pin_enable_i(eb),
    .pin_a_direction_bit_i(da), .pin_b_direction_bit_i(db), .timer_gate_o(tg),
    .timer_increment_o(ti), .comp_b_synced_output_o(sy), .comp_a_status_o(sa),
    .comp_b_status_o(sb), .comp_a_reference_select_o(), .comp_b_reference_select_o(),
    .ladder_current_enable_o(), .fixed_reference_enable_o(), .pin_a_out_o(pa),
    .pin_a_oe_o(oa), .pin_b_out_o(pb), .pin_b_oe_o(ob), .latch_q_o(lq));
  cmpl_far far (.clock_i(clock_i), .timer_increment_i(ti), .comp_a_o(ca),
    .comp_b_o(cb), .gate_pin_o(eg), .raw_clk_o(rc), .presc_clk_o(pc));
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : wt
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    ad <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
    @(posedge clock_i);
  endtask : wreg
  // Read data is only valid in the cycle after the strobe
  task automatic rdv(input logic [3:0] a, input logic [7:0] e, input string m);
    @(posedge clock_i);
    ad <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1 chk(rdo, e, m);
  endtask : rdv
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  // ****
  // Main sequence
  // ****
  initial begin
    {resetn_i, wr, rd, ea, eb, pu, ad, wd} = '0;
    {da, db} = 2'h3;
    repeat (10) @(posedge clock_i);
    resetn_i <= 1'b1;
    rdv(4'h0, 8'h02, "shared reset");
    rdv(4'h1, 8'h00, "latch reset");
    foreach (rows[i]) begin
      wreg(rows[i].a, rows[i].w);
      rdv(rows[i].a, rows[i].e, "table");
    end
    $display("test registers done");
    far.set_in(1'b1, 1'b0, 1'b0);
    wt(8);
    chk(pa, 1'b1, "pin A default");
    chk(pb, 1'b0, "pin B default");
    chk(sa, 1'b1, "status A");
    rdv(4'h0, 8'h82, "mirror A");
    far.set_in(1'b0, 1'b1, 1'b0);
    wt(8);
    chk(sb, 1'b1, "status B");
    rdv(4'h0, 8'h42, "mirror B");
    $display("test mirrors done");
    wreg(4'h1, 8'h30);
    far.set_in(1'b1, 1'b0, 1'b0);
    wt(8);
    chk(lq, 1'b1, "comp A sets");
    far.set_in(1'b1, 1'b1, 1'b0);
    wt(8);
    chk(lq, 1'b0, "reset wins");
    wreg(4'h1, 8'h00);
    far.set_in(1'b1, 1'b0, 1'b0);
    wt(8);
    chk(lq, 1'b0, "set disabled");
    wreg(4'h1, 8'h08);
    wt(2);
    chk(lq, 1'b1, "set pulse");
    rdv(4'h1, 8'h00, "pulse clears");
    far.set_in(1'b0, 1'b1, 1'b0);
    wt(8);
    chk(lq, 1'b1, "reset disabled");
    wreg(4'h1, 8'h04);
    wt(2);
    chk(lq, 1'b0, "reset pulse");
    wreg(4'h1, 8'hC8);
    wt(8);
    chk(pa, 1'b1, "pin A latch");
    chk(pb, 1'b0, "pin B latch inverted");
    chk(sa, 1'b0, "status not pin");
    wreg(4'h1, 8'h00);
    wt(4);
    chk({pa, pb}, 2'h1, "pins plain");
    $display("test latch done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_i);
      {da, ea} <= i[1:0];
      {eb, db} <= i[1:0];
      wt(3);
      chk(oa, i[0] & ~i[1], "oe A");
      chk(ob, i[1] & ~i[0], "oe B");
    end
    wreg(4'h0, 8'h00);
    wt(8);
    chk({tg, sy}, 2'h3, "gate from comp B");
    far.set_in(1'b0, 1'b0, 1'b1);
    wt(8);
    chk(tg, 1'b0, "pin ignored");
    wreg(4'h0, 8'h02);
    wt(8);
    chk(tg, 1'b1, "gate from pin");
    far.tclk(1'b0, 3);
    wt(8);
    chk(8'(far.incs), 8'h03, "increments");
    // sync set while comp B gates
    wreg(4'h0, 8'h01);
    far.set_in(1'b0, 1'b1, 1'b0);
    wt(8);
    chk(sy, 1'b0, "held until fall");
    far.tclk(1'b0, 1);
    wt(8);
    chk(sy, 1'b1, "captured on fall");
    @(posedge clock_i);
    pu <= 1'b1;
    far.set_in(1'b0, 1'b0, 1'b0);
    far.tclk(1'b0, 2);
    wt(8);
    chk(sy, 1'b1, "raw clock ignored");
    far.tclk(1'b1, 1);
    wt(8);
    chk(sy, 1'b0, "prescaled capture");
    $display("test timer done");
    // Reset in mid-run must drop latched pin routing and restore both registers
    wreg(4'h1, 8'hC8);
    far.set_in(1'b1, 1'b0, 1'b0);
    wt(8);
    chk({pa, pb, lq}, 3'h5, "latched pins before reset");
    @(posedge clock_i);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    resetn_i <= 1'b1;
    wt(8);
    chk({pa, pb, lq}, 3'h4, "plain pins after reset");
    rdv(4'h0, 8'h82, "shared after reset");
    rdv(4'h1, 8'h00, "latch reg after reset");
    $display("test reset done");
    complete_run();
  end
endmodule : tb
